// *** core/sos_pkg.sv ***
// Summary of operation
// [RQ1] Cost is clocks plus bus reads and writes
// [RQ2] Flagged forms add address cost per component
// [RQ3] Condition-set and atomic use nonfetching address cost
// [RQ4] Negate family: register 4/6, memory 8(1/1)+
// [RQ5] Negate family long memory: 12(1/2)+
// [RQ6] Bcd sign flip byte: register 6, memory 8+
// [RQ7] Condition set: register 4, memory 8(1/1); the code adds the nonfetching address cost on top for memory
// [RQ8] Atomic flag byte: register 4, memory 14(2/1)+
// [RQ9] Operand check: always 4(1/0), memory adds cost
// [RQ10] Zeroing: fixed per mode, address register refused
// [RQ11] Zeroing indexed time ignores index size
// [RQ12] Zeroing loop continue performs no reads
// [RQ13] Bcd loop: 18/24/22, predecrement adds 2
// [RQ14] Negate family long loop: 24(2/2), 30(4/2)
// [RQ15] Check long loop: 18(2/0), true 24(4/0)
// [RQ16] Register shift: 6+2n or 8+2n, one read
// [RQ17] Memory shift word only: 8(1/1)+
// [RQ18] Shift loop: 18/24/22, predecrement adds 2
// [RQ19] Loop continue holds opcode, no new fetch
// [RQ20] Loop figures exclude address cost; three outcomes
package sos_pkg;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [3:0] {
      OP_ZEROING = 4'h0, OP_BCD_SIGN_FLIP = 4'h1, OP_TWOS_COMPLEMENT = 4'h2,
      OP_TWOS_COMPLEMENT_EXTEND = 4'h3, OP_INVERT = 4'h4, OP_COND_SET = 4'h5,
      OP_ATOMIC_FLAG = 4'h6, OP_OPERAND_CHECK = 4'h7, OP_ARITH_SHIFT = 4'h8,
      OP_LOGIC_SHIFT = 4'h9, OP_CIRCULAR_SHIFT = 4'hA, OP_EXTENDED_CIRCULAR = 4'hB
   } sos_op_t;
   typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} sos_size_t;
   typedef enum logic [3:0] {
      MODE_DATA_REG = 4'h0, MODE_ADDRESS_REG = 4'h1, MODE_INDIRECT = 4'h2,
      MODE_POSTINC = 4'h3, MODE_PREDEC = 4'h4, MODE_DISP = 4'h5,
      MODE_INDEX = 4'h6, MODE_ABS_SHORT = 4'h7, MODE_ABS_LONG = 4'h8
   } sos_mode_t;
   typedef enum logic [1:0] {
      LOOP_CONTINUE = 2'h0, LOOP_EXIT_TRUE = 2'h1, LOOP_EXIT_EXPIRED = 2'h2
   } sos_outcome_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [7:0] clocks;   // Clock periods
      logic [3:0] reads;    // Bus read cycles
      logic [3:0] writes;   // Bus write cycles
   } sos_cost_t;
   typedef struct packed {
      sos_op_t op;
      sos_size_t size;
      sos_mode_t mode;
      logic [5:0] count;        // Shift count n
      logic loop;               // Repeated inside a decrement-and-branch loop
      sos_outcome_t outcome;    // Loop outcome of this iteration
      sos_cost_t eaFetch;       // Fetching address cost
      sos_cost_t eaNofetch;     // Nonfetching address cost
   } sos_req_t;

   // ****************************************
   // Cost figures
   // ****************************************
   localparam sos_cost_t COST_NONE = '{8'h00, 4'h0, 4'h0};
   localparam sos_cost_t COST_REG_BW = '{8'h04, 4'h1, 4'h0};
   localparam sos_cost_t COST_REG_L = '{8'h06, 4'h1, 4'h0};
   localparam sos_cost_t COST_BCD_REG = '{8'h06, 4'h1, 4'h0};
   localparam sos_cost_t COST_MEM_BW = '{8'h08, 4'h1, 4'h1};
   localparam sos_cost_t COST_MEM_L = '{8'h0C, 4'h1, 4'h2};
   localparam sos_cost_t COST_ATOMIC_MEM = '{8'h0E, 4'h2, 4'h1};
   localparam sos_cost_t COST_SHIFT_BW = '{8'h06, 4'h1, 4'h0};
   localparam sos_cost_t COST_SHIFT_L = '{8'h08, 4'h1, 4'h0};
   localparam logic [7:0] SHIFT_STEP = 8'h02;
   localparam logic [7:0] PREDEC_EXTRA = 8'h02;
   // Zeroing on memory, indexed by mode minus MODE_INDIRECT
   localparam sos_cost_t ZERO_MEM_BW [7] = '{'{8'h08, 4'h1, 4'h1}, '{8'h08, 4'h1, 4'h1},
      '{8'h0A, 4'h1, 4'h1}, '{8'h0C, 4'h2, 4'h1}, '{8'h10, 4'h2, 4'h1},
      '{8'h0C, 4'h2, 4'h1}, '{8'h10, 4'h3, 4'h1}};
   localparam sos_cost_t ZERO_MEM_L [7] = '{'{8'h0C, 4'h1, 4'h2}, '{8'h0C, 4'h1, 4'h2},
      '{8'h0E, 4'h1, 4'h2}, '{8'h10, 4'h2, 4'h2}, '{8'h14, 4'h2, 4'h2},
      '{8'h10, 4'h2, 4'h2}, '{8'h14, 4'h3, 4'h2}};
   // Loop figures, indexed by outcome, without predecrement
   localparam sos_cost_t LOOP_ZERO_BW [3] = '{'{8'h0A, 4'h0, 4'h1},
      '{8'h12, 4'h2, 4'h1}, '{8'h10, 4'h2, 4'h1}};
   localparam sos_cost_t LOOP_ZERO_L [3] = '{'{8'h0E, 4'h0, 4'h2},
      '{8'h16, 4'h2, 4'h2}, '{8'h14, 4'h2, 4'h2}};
   localparam sos_cost_t LOOP_RMW_BW [3] = '{'{8'h12, 4'h1, 4'h1},
      '{8'h18, 4'h3, 4'h1}, '{8'h16, 4'h3, 4'h1}};
   localparam sos_cost_t LOOP_NEG_BW [3] = '{'{8'h10, 4'h1, 4'h1},
      '{8'h16, 4'h3, 4'h1}, '{8'h14, 4'h3, 4'h1}};
   localparam sos_cost_t LOOP_NEG_L [3] = '{'{8'h18, 4'h2, 4'h2},
      '{8'h1E, 4'h4, 4'h2}, '{8'h1C, 4'h4, 4'h2}};
   localparam sos_cost_t LOOP_CHECK_BW [3] = '{'{8'h0C, 4'h1, 4'h0},
      '{8'h12, 4'h3, 4'h0}, '{8'h10, 4'h3, 4'h0}};
   localparam sos_cost_t LOOP_CHECK_L [3] = '{'{8'h12, 4'h2, 4'h0},
      '{8'h18, 4'h4, 4'h0}, '{8'h14, 4'h4, 4'h0}};

endpackage : sos_pkg

// *** core/sos_single_operand_timing.sv ***
`timescale 1ns/1ps
module sos_single_operand_timing (
   input wire logic mclk,                     // 25 MHz processor clock
   input wire logic rst_n,                    // Asynchronous reset, active low
   input wire logic ce,                       // Clock enable, freezes all state when low
   input wire logic reqValid,                 // Instruction descriptor offered
   input wire sos_pkg::sos_req_t req,         // Instruction descriptor
   output logic reqReady,                     // Sequencer idle
   output logic busy,                         // Instruction running
   output logic readStrobe,                   // One bus read cycle
   output logic writeStrobe,                  // One bus write cycle
   output logic done,                         // Last clock of the instruction
   output logic rejected,                     // Descriptor has no legal timing
   output logic opcodeHeld,                   // Opcode held, no fetch this iteration
   output sos_pkg::sos_cost_t cost            // Accounted cost of the current instruction
);

   // ****************************************
   // State and signals
   // ****************************************
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} sos_state_t;
   sos_state_t state, next_state;
   logic [7:0] elapsed, next_elapsed;        // Clocks spent so far
   logic next_rejected;
   logic next_opcodeHeld;
   sos_pkg::sos_cost_t next_cost;
   sos_pkg::sos_cost_t calcCost;             // Figure for the offered descriptor
   logic calcLegal;                          // Descriptor has a timing
   logic accept;                             // Descriptor offered while idle on an enabled clock, legal or not
   logic isMem;                              // Operand in memory
   logic isLong;
   logic [2:0] memIdx;                       // Row of the zeroing tables
   logic [8:0] wrEnd;                        // Elapsed count after the last write

   // Operand class of the offered descriptor
   assign isMem = req.mode >= sos_pkg::MODE_INDIRECT;
   assign isLong = req.size == sos_pkg::SZ_LONG;
   assign memIdx = 3'(req.mode - sos_pkg::MODE_INDIRECT);

   // ****************************************
   // Cost calculation
   // ****************************************
   always_comb begin
      logic addEa;
      logic useNofetch;
      sos_pkg::sos_cost_t ea;
      // Working values set first, so no latch forms
      addEa = 1'b0;
      useNofetch = 1'b0;
      ea = sos_pkg::COST_NONE;
      calcCost = sos_pkg::COST_NONE;
      calcLegal = 1'b1;
      // No operation here accepts an address register or an unused size
      if (req.mode == sos_pkg::MODE_ADDRESS_REG || req.size > sos_pkg::SZ_LONG ||
          req.mode > sos_pkg::MODE_ABS_LONG) begin
         calcLegal = 1'b0; // RQ10
      end else if (req.loop) begin
         // Loop figures include the branch, no address cost added
         if (req.mode > sos_pkg::MODE_PREDEC || req.mode < sos_pkg::MODE_INDIRECT ||
             req.outcome > sos_pkg::LOOP_EXIT_EXPIRED) begin
            calcLegal = 1'b0; // RQ20
         end else begin
            case (req.op)
               sos_pkg::OP_ZEROING: begin
                  calcCost = isLong ? sos_pkg::LOOP_ZERO_L[req.outcome] :
                     sos_pkg::LOOP_ZERO_BW[req.outcome]; // RQ12
               end
               sos_pkg::OP_BCD_SIGN_FLIP: begin
                  calcLegal = req.size == sos_pkg::SZ_BYTE;
                  calcCost = sos_pkg::LOOP_RMW_BW[req.outcome]; // RQ13
               end
               sos_pkg::OP_TWOS_COMPLEMENT, sos_pkg::OP_TWOS_COMPLEMENT_EXTEND,
               sos_pkg::OP_INVERT: begin
                  calcCost = isLong ? sos_pkg::LOOP_NEG_L[req.outcome] :
                     sos_pkg::LOOP_NEG_BW[req.outcome]; // RQ14
               end
               sos_pkg::OP_OPERAND_CHECK: begin
                  calcCost = isLong ? sos_pkg::LOOP_CHECK_L[req.outcome] :
                     sos_pkg::LOOP_CHECK_BW[req.outcome]; // RQ15
               end
               sos_pkg::OP_ARITH_SHIFT, sos_pkg::OP_LOGIC_SHIFT,
               sos_pkg::OP_CIRCULAR_SHIFT, sos_pkg::OP_EXTENDED_CIRCULAR: begin
                  calcLegal = req.size == sos_pkg::SZ_WORD;
                  calcCost = sos_pkg::LOOP_RMW_BW[req.outcome]; // RQ18
               end
               default: begin
                  calcLegal = 1'b0; // RQ19
               end
            endcase
            // Predecrement costs two more clocks in every outcome
            if (req.mode == sos_pkg::MODE_PREDEC) begin
               calcCost.clocks = calcCost.clocks + sos_pkg::PREDEC_EXTRA; // RQ13 RQ18
            end
         end
      end else begin
         case (req.op)
            sos_pkg::OP_ZEROING: begin
               // Fixed per mode; index register size plays no part
               if (isMem) begin
                  calcCost = isLong ? sos_pkg::ZERO_MEM_L[memIdx] :
                     sos_pkg::ZERO_MEM_BW[memIdx]; // RQ10 RQ11
               end else begin
                  calcCost = isLong ? sos_pkg::COST_REG_L : sos_pkg::COST_REG_BW; // RQ10
               end
            end
            sos_pkg::OP_BCD_SIGN_FLIP: begin
               calcLegal = req.size == sos_pkg::SZ_BYTE;
               calcCost = isMem ? sos_pkg::COST_MEM_BW : sos_pkg::COST_BCD_REG; // RQ6
               addEa = isMem;
            end
            sos_pkg::OP_TWOS_COMPLEMENT, sos_pkg::OP_TWOS_COMPLEMENT_EXTEND,
            sos_pkg::OP_INVERT: begin
               if (isMem) begin
                  calcCost = isLong ? sos_pkg::COST_MEM_L : sos_pkg::COST_MEM_BW; // RQ4 RQ5
               end else begin
                  calcCost = isLong ? sos_pkg::COST_REG_L : sos_pkg::COST_REG_BW; // RQ4
               end
               addEa = isMem;
            end
            sos_pkg::OP_COND_SET: begin
               calcLegal = req.size == sos_pkg::SZ_BYTE;
               calcCost = isMem ? sos_pkg::COST_MEM_BW : sos_pkg::COST_REG_BW; // RQ7
               addEa = isMem;
               useNofetch = 1'b1; // RQ3
            end
            sos_pkg::OP_ATOMIC_FLAG: begin
               calcLegal = req.size == sos_pkg::SZ_BYTE;
               calcCost = isMem ? sos_pkg::COST_ATOMIC_MEM : sos_pkg::COST_REG_BW; // RQ8
               addEa = isMem;
               useNofetch = 1'b1; // RQ3
            end
            sos_pkg::OP_OPERAND_CHECK: begin
               calcCost = sos_pkg::COST_REG_BW; // RQ9
               addEa = isMem;
            end
            sos_pkg::OP_ARITH_SHIFT, sos_pkg::OP_LOGIC_SHIFT,
            sos_pkg::OP_CIRCULAR_SHIFT, sos_pkg::OP_EXTENDED_CIRCULAR: begin
               if (isMem) begin
                  calcLegal = req.size == sos_pkg::SZ_WORD; // RQ17
                  calcCost = sos_pkg::COST_MEM_BW;
                  addEa = 1'b1;
               end else begin
                  calcCost = isLong ? sos_pkg::COST_SHIFT_L : sos_pkg::COST_SHIFT_BW;
                  calcCost.clocks = 8'(calcCost.clocks + sos_pkg::SHIFT_STEP * req.count); // RQ16
               end
            end
            default: begin
               calcLegal = 1'b0;
            end
         endcase
      end
      // Address cost added component by component
      ea = useNofetch ? req.eaNofetch : req.eaFetch;
      if (addEa) begin
         calcCost.clocks = calcCost.clocks + ea.clocks; // RQ2
         calcCost.reads = calcCost.reads + ea.reads; // RQ2
         calcCost.writes = calcCost.writes + ea.writes; // RQ2
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   // Handshake and strobes decoded from the state and the elapsed count
   assign reqReady = state == ST_IDLE;
   assign busy = state == ST_RUN;
   assign accept = ce && reqValid && reqReady;
   assign wrEnd = {5'h00, cost.reads} + {5'h00, cost.writes};
   // Reads first, then writes, one per clock, inside the counted clocks
   assign readStrobe = busy && elapsed < {4'h0, cost.reads}; // RQ1
   assign writeStrobe = busy && !readStrobe && {1'b0, elapsed} < wrEnd; // RQ1
   assign done = busy && elapsed == 8'(cost.clocks - 8'h01); // RQ1

   // Next state of the sequencer
   always_comb begin
      next_state = state;
      next_elapsed = elapsed;
      next_cost = cost;
      next_rejected = 1'b0;
      next_opcodeHeld = opcodeHeld;
      case (state)
         ST_IDLE: begin
            if (reqValid && calcLegal) begin
               next_state = ST_RUN;
               next_elapsed = 8'h00;
               next_cost = calcCost;
               // Continuing loop iteration reuses the held opcode
               next_opcodeHeld = req.loop && req.outcome == sos_pkg::LOOP_CONTINUE; // RQ19
            end else if (reqValid) begin
               next_rejected = 1'b1;
            end
         end
         ST_RUN: begin
            if (done) begin
               next_state = ST_IDLE;
               next_opcodeHeld = 1'b0;
            end else begin
               next_elapsed = elapsed + 8'h01;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Registers of the sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         elapsed <= 8'h00;
         cost <= sos_pkg::COST_NONE;
         rejected <= 1'b0;
         opcodeHeld <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         elapsed <= next_elapsed;
         cost <= next_cost;
         rejected <= next_rejected;
         opcodeHeld <= next_opcodeHeld;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [3:0] rdSeen;   // Reads issued in this instruction
   logic [3:0] wrSeen;   // Writes issued in this instruction
   // Tallies of the strobes inside the running instruction
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdSeen <= 4'h0;
         wrSeen <= 4'h0;
      end else if (ce) begin
         rdSeen <= (done || !busy) ? 4'h0 : rdSeen + {3'h0, readStrobe};
         wrSeen <= (done || !busy) ? 4'h0 : wrSeen + {3'h0, writeStrobe};
      end
   end

   // Checks sample only on enabled clocks and rest during reset
   default clocking cb @(posedge mclk iff ce); endclocking
   default disable iff (!rst_n);

   read_count_a: assert property (done |-> rdSeen + {3'h0, readStrobe} == cost.reads) // RQ1
      else $error("read cycles differ from accounted reads");
   write_count_a: assert property (done |-> wrSeen + {3'h0, writeStrobe} == cost.writes) // RQ1
      else $error("write cycles differ from accounted writes");
   run_length_a: assert property ($rose(busy) |-> busy throughout (##[0:300] done)) // RQ1
      else $error("instruction did not finish");
   strobe_excl_a: assert property (!(readStrobe && writeStrobe)) // RQ1
      else $error("read and write strobes together");
   idle_quiet_a: assert property (!busy |-> !readStrobe && !writeStrobe && !done) // RQ1
      else $error("bus activity while idle");
   ea_added_a: assert property (accept && !req.loop && isMem && isLong && calcLegal && // RQ2 RQ5
      req.op inside {sos_pkg::OP_TWOS_COMPLEMENT, sos_pkg::OP_TWOS_COMPLEMENT_EXTEND,
      sos_pkg::OP_INVERT} |=> cost.clocks == 8'h0C + $past(req.eaFetch.clocks) &&
      cost.writes == 4'h2 + $past(req.eaFetch.writes))
      else $error("long memory negate family cost wrong");
   nofetch_used_a: assert property (accept && !req.loop && isMem && calcLegal && // RQ3 RQ8
      req.op == sos_pkg::OP_ATOMIC_FLAG |=> cost.clocks == 8'h0E + $past(req.eaNofetch.clocks))
      else $error("atomic flag not using nonfetching cost");
   condset_mem_a: assert property (accept && !req.loop && isMem && calcLegal && // RQ3 RQ7
      req.op == sos_pkg::OP_COND_SET |=> cost.reads == 4'h1 + $past(req.eaNofetch.reads))
      else $error("condition set memory reads wrong");
   bcd_reg_a: assert property (accept && !req.loop && !isMem && calcLegal && // RQ6
      req.op == sos_pkg::OP_BCD_SIGN_FLIP |=> cost == sos_pkg::COST_BCD_REG)
      else $error("bcd register cost wrong");
   check_cost_a: assert property (accept && !req.loop && calcLegal && // RQ9
      req.op == sos_pkg::OP_OPERAND_CHECK |=> cost.writes == 4'h0 && cost.clocks ==
      8'h04 + ($past(isMem) ? $past(req.eaFetch.clocks) : 8'h00))
      else $error("operand check cost wrong");
   zero_areg_a: assert property (accept && req.mode == sos_pkg::MODE_ADDRESS_REG // RQ10
      |=> rejected && !busy)
      else $error("address register zeroing accepted");
   zero_loop_a: assert property (accept && calcLegal && req.loop && // RQ12
      req.op == sos_pkg::OP_ZEROING && req.outcome == sos_pkg::LOOP_CONTINUE
      |=> !readStrobe [*3])
      else $error("zeroing loop performed a read");
   reg_shift_a: assert property (accept && calcLegal && !req.loop && !isMem && !isLong && // RQ16
      req.op == sos_pkg::OP_LOGIC_SHIFT |=> cost.clocks == 8'h06 + 8'($past(req.count)) * 8'h02)
      else $error("register shift clocks wrong");
   mem_shift_a: assert property (accept && !req.loop && isMem && isLong && // RQ17
      req.op >= sos_pkg::OP_ARITH_SHIFT |=> rejected && !busy)
      else $error("long memory shift accepted");
   neg_loop_a: assert property (accept && calcLegal && req.loop && isLong && // RQ14
      req.op == sos_pkg::OP_TWOS_COMPLEMENT_EXTEND && req.outcome == sos_pkg::LOOP_EXIT_TRUE
      |=> cost.clocks == 8'h1E && cost.reads == 4'h4 && cost.writes == 4'h2)
      else $error("negate family long loop exit cost wrong");
   loop_held_a: assert property (accept && calcLegal && req.loop && // RQ19
      req.outcome == sos_pkg::LOOP_CONTINUE |=> opcodeHeld until done)
      else $error("continuing loop fetched an opcode");
   loop_predec_a: assert property (accept && calcLegal && req.loop && // RQ18 RQ20
      req.mode == sos_pkg::MODE_PREDEC && req.op >= sos_pkg::OP_ARITH_SHIFT &&
      req.outcome == sos_pkg::LOOP_CONTINUE |=> cost.clocks == 8'h14)
      else $error("shift loop predecrement clocks wrong");

   // Main scenarios worth seeing
   loop_run_c: cover property (accept && calcLegal && req.loop ##1 busy [*3]);
   reject_c: cover property (accept && !calcLegal ##1 rejected);
   mem_write_c: cover property (writeStrobe ##1 writeStrobe ##[1:20] done);
   long_shift_c: cover property (accept && calcLegal && isLong && !isMem && req.count > 6'h02);
   loop_exit_c: cover property (accept && calcLegal && req.loop &&
      req.outcome == sos_pkg::LOOP_EXIT_EXPIRED);

endmodule : sos_single_operand_timing

// *** verification/sos_bus_model.sv ***
`timescale 1ns/1ps
// ****************************************
// System bus memory model
// ****************************************
module sos_bus_model (
   input wire logic mclk,         // Processor clock
   input wire logic rst_n,        // Asynchronous reset, active low
   input wire logic clearCount,   // Starts a new tally
   input wire logic readStrobe,   // Bus read request
   input wire logic writeStrobe,  // Bus write request
   output logic [3:0] readCount,  // Reads served since clear
   output logic [3:0] writeCount  // Writes served since clear
);
   // Serves each strobe in the cycle it stands and tallies it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         readCount <= 4'h0;
         writeCount <= 4'h0;
      end else if (clearCount) begin
         readCount <= 4'h0;
         writeCount <= 4'h0;
      end else begin
         readCount <= readCount + {3'h0, readStrobe};
         writeCount <= writeCount + {3'h0, writeStrobe};
      end
   end
endmodule : sos_bus_model

// *** verification/tb_single_operand_shift_timing.sv ***
`timescale 1ns/1ps
module tb_single_operand_shift_timing;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic mclk, rst_n, ce, reqValid, clearCount; // Bench driven
   sos_pkg::sos_req_t req; // Descriptor offered
   logic reqReady, busy, readStrobe, writeStrobe, done, rejected, opcodeHeld; // Observed
   sos_pkg::sos_cost_t cost; // Accounted cost
   logic [3:0] readCount, writeCount; // Bus tallies
   int errTotal, checks; // Mismatches and comparisons
   localparam sos_pkg::sos_cost_t EA_F = 16'h0410; // Fetching address cost
   localparam sos_pkg::sos_cost_t EA_N = 16'h0200; // Nonfetching address cost
   localparam sos_pkg::sos_cost_t REJ = 16'h0000; // Marks a refused descriptor

   sos_single_operand_timing i_sos_single_operand_timing (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .busy(busy),
      .readStrobe(readStrobe), .writeStrobe(writeStrobe), .done(done), .rejected(rejected),
      .opcodeHeld(opcodeHeld), .cost(cost));
   sos_bus_model i_sos_bus_model (.mclk(mclk), .rst_n(rst_n), .clearCount(clearCount),
      .readStrobe(readStrobe), .writeStrobe(writeStrobe), .readCount(readCount),
      .writeCount(writeCount));

   // Free running 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chkCost(input string name, input sos_pkg::sos_cost_t exp,
      input sos_pkg::sos_cost_t got);
      checks++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chkCost

   task automatic chkBit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask : chkBit

   task automatic testDone;
      $display("Comparisons %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : testDone

   // Offers one descriptor, then times it and tallies its bus cycles
   task automatic go(input sos_pkg::sos_cost_t exp, input logic held, input sos_pkg::sos_op_t op,
      input sos_pkg::sos_size_t sz, input sos_pkg::sos_mode_t md, input logic [5:0] n,
      input logic lp, input sos_pkg::sos_outcome_t oc);
      int cyc;
      req = '{op, sz, md, n, lp, oc, EA_F, EA_N};
      reqValid = 1'b1;
      clearCount = 1'b1;
      @(posedge mclk) #1;
      reqValid = 1'b0;
      clearCount = 1'b0;
      if (exp === REJ) begin
         chkBit("rejected", 1'b1, rejected);
         chkBit("busy", 1'b0, busy);
         @(posedge mclk) #1;
      end else begin
         chkCost("cost port", exp, cost);
         chkBit("opcodeHeld", held, opcodeHeld);
         cyc = 1;
         while (done !== 1'b1 && cyc < 300) begin
            @(posedge mclk) #1;
            cyc++;
         end
         if (cyc >= 300) begin
            errTotal++;
            $display("[FAIL] done expected 1 seen %b", done);
         end else begin
            @(posedge mclk) #1;
            chkCost("counted cost", exp, {cyc[7:0], readCount, writeCount});
            chkBit("reqReady", 1'b1, reqReady);
            chkBit("opcodeHeld after", 1'b0, opcodeHeld);
         end
      end
   endtask : go

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic tNegate;
      go(16'h0C21, 0, sos_pkg::OP_TWOS_COMPLEMENT, sos_pkg::SZ_WORD, sos_pkg::MODE_INDIRECT, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h0610, 0, sos_pkg::OP_INVERT, sos_pkg::SZ_LONG, sos_pkg::MODE_DATA_REG, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1022, 0, sos_pkg::OP_TWOS_COMPLEMENT_EXTEND, sos_pkg::SZ_LONG, sos_pkg::MODE_DISP,
         0, 0, sos_pkg::LOOP_CONTINUE);
   endtask : tNegate

   task automatic tByteOps;
      go(16'h0610, 0, sos_pkg::OP_BCD_SIGN_FLIP, sos_pkg::SZ_BYTE, sos_pkg::MODE_DATA_REG, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h0A11, 0, sos_pkg::OP_COND_SET, sos_pkg::SZ_BYTE, sos_pkg::MODE_INDIRECT, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1021, 0, sos_pkg::OP_ATOMIC_FLAG, sos_pkg::SZ_BYTE, sos_pkg::MODE_POSTINC, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h0820, 0, sos_pkg::OP_OPERAND_CHECK, sos_pkg::SZ_LONG, sos_pkg::MODE_ABS_SHORT, 0,
         0, sos_pkg::LOOP_CONTINUE);
   endtask : tByteOps

   task automatic tZeroing;
      go(16'h0C21, 0, sos_pkg::OP_ZEROING, sos_pkg::SZ_WORD, sos_pkg::MODE_ABS_SHORT, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1031, 0, sos_pkg::OP_ZEROING, sos_pkg::SZ_BYTE, sos_pkg::MODE_ABS_LONG, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1021, 0, sos_pkg::OP_ZEROING, sos_pkg::SZ_WORD, sos_pkg::MODE_INDEX, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(REJ, 0, sos_pkg::OP_ZEROING, sos_pkg::SZ_WORD, sos_pkg::MODE_ADDRESS_REG, 0, 0,
         sos_pkg::LOOP_CONTINUE);
   endtask : tZeroing

   task automatic tLoops;
      go(16'h0E02, 1, sos_pkg::OP_ZEROING, sos_pkg::SZ_LONG, sos_pkg::MODE_POSTINC, 0, 1,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1831, 0, sos_pkg::OP_BCD_SIGN_FLIP, sos_pkg::SZ_BYTE, sos_pkg::MODE_INDIRECT, 0, 1,
         sos_pkg::LOOP_EXIT_TRUE);
      go(16'h1831, 0, sos_pkg::OP_BCD_SIGN_FLIP, sos_pkg::SZ_BYTE, sos_pkg::MODE_PREDEC, 0, 1,
         sos_pkg::LOOP_EXIT_EXPIRED);
      go(16'h1822, 1, sos_pkg::OP_TWOS_COMPLEMENT, sos_pkg::SZ_LONG, sos_pkg::MODE_INDIRECT, 0,
         1, sos_pkg::LOOP_CONTINUE);
      go(16'h1E42, 0, sos_pkg::OP_TWOS_COMPLEMENT_EXTEND, sos_pkg::SZ_LONG,
         sos_pkg::MODE_POSTINC, 0, 1, sos_pkg::LOOP_EXIT_TRUE);
      go(16'h1220, 1, sos_pkg::OP_OPERAND_CHECK, sos_pkg::SZ_LONG, sos_pkg::MODE_POSTINC, 0, 1,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1840, 0, sos_pkg::OP_OPERAND_CHECK, sos_pkg::SZ_LONG, sos_pkg::MODE_INDIRECT, 0,
         1, sos_pkg::LOOP_EXIT_TRUE);
      go(REJ, 0, sos_pkg::OP_ZEROING, sos_pkg::SZ_WORD, sos_pkg::MODE_DISP, 0, 1,
         sos_pkg::LOOP_CONTINUE);
   endtask : tLoops

   task automatic tShifts;
      go(16'h1010, 0, sos_pkg::OP_LOGIC_SHIFT, sos_pkg::SZ_WORD, sos_pkg::MODE_DATA_REG, 5, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h0E10, 0, sos_pkg::OP_CIRCULAR_SHIFT, sos_pkg::SZ_LONG, sos_pkg::MODE_DATA_REG, 3,
         0, sos_pkg::LOOP_CONTINUE);
      go(16'h0C21, 0, sos_pkg::OP_ARITH_SHIFT, sos_pkg::SZ_WORD, sos_pkg::MODE_INDIRECT, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(REJ, 0, sos_pkg::OP_EXTENDED_CIRCULAR, sos_pkg::SZ_LONG, sos_pkg::MODE_INDIRECT, 0, 0,
         sos_pkg::LOOP_CONTINUE);
      go(16'h1411, 1, sos_pkg::OP_EXTENDED_CIRCULAR, sos_pkg::SZ_WORD, sos_pkg::MODE_PREDEC, 0,
         1, sos_pkg::LOOP_CONTINUE);
      go(16'h1631, 0, sos_pkg::OP_LOGIC_SHIFT, sos_pkg::SZ_WORD, sos_pkg::MODE_POSTINC, 0, 1,
         sos_pkg::LOOP_EXIT_EXPIRED);
   endtask : tShifts

   // Clock enable low holds the sequencer; the descriptor is taken once it rises
   task automatic tFreeze;
      ce = 1'b0;
      req = '{sos_pkg::OP_BCD_SIGN_FLIP, sos_pkg::SZ_BYTE, sos_pkg::MODE_DATA_REG, 6'h00, 1'b0,
         sos_pkg::LOOP_CONTINUE, EA_F, EA_N};
      reqValid = 1'b1;
      @(posedge mclk) #1;
      chkBit("frozen busy", 1'b0, busy);
      ce = 1'b1;
      @(posedge mclk) #1;
      reqValid = 1'b0;
      chkCost("thawed cost", 16'h0610, cost);
      repeat (6) @(posedge mclk) #1;
      chkBit("thawed reqReady", 1'b1, reqReady);
   endtask : tFreeze

   // Reset, then every scenario back to back
   initial begin
      errTotal = 0;
      checks = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      reqValid = 1'b0;
      clearCount = 1'b0;
      req = '0;
      repeat (3) @(posedge mclk);
      #1 rst_n = 1'b1;
      @(posedge mclk) #1;
      tNegate();
      tByteOps();
      tZeroing();
      tLoops();
      tShifts();
      tFreeze();
      testDone();
   end
endmodule : tb_single_operand_shift_timing
